// >>> dmai_pkg.sv
// Behaviour
// - Fill level counts responses not yet retrieved
// - Responses drain via stream port or bus
// - Disabled response port reads fill level zero
// - Write sequence shows next write-engine descriptor
// - Read sequence shows next read-engine descriptor
// - Memory-to-stream mode reads both sequences zero
// - Sequence fields exist only with extended features
// - Early termination is bit 8 of word two
// - Word one bits 0-2 flag burst, wrap, channel
// - Bits 5:3 hold channel count minus one
// - Bits 9:6 hold data FIFO depth exponent
// - Bits 12:10 hold datapath width exponent
// - Bits 15:13 hold descriptor FIFO depth exponent
// - Bits 17:16 hold the transfer mode
// - Bit 18 extended features, bit 19 errors
// - Bits 22:20 hold error lines minus one
// - Bits 26:23 hold maximum burst exponent
// - Bits 31:27 hold maximum transfer length exponent
// - Word two bit 0 stride, 15:1 stride
// - Word two bits 16-18 packet, prefetch, burst
// - Bits 20:19 hold the response port type
// - Bits 22:21 access type, 31:23 reserved
// - Reading response byte seven pops the response
package dmai_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_RESP_BYTES = 8'h00;
  localparam logic [7:0] OFF_RESP_INFO  = 8'h04;
  localparam logic [7:0] OFF_FILL       = 8'h08;
  localparam logic [7:0] OFF_WSEQ       = 8'h0C;
  localparam logic [7:0] OFF_RSEQ       = 8'h10;
  localparam logic [7:0] OFF_CFG1       = 8'h14;
  localparam logic [7:0] OFF_CFG2       = 8'h18;
  localparam logic [7:0] OFF_RCTRL      = 8'h1C;

  // Field positions
  localparam int ET_BIT    = 8;
  localparam int FLUSH_BIT = 0;

  // Response FIFO geometry
  localparam int         RESP_AW    = 4;
  localparam int         RESP_DEPTH = 16;
  localparam logic [4:0] RESP_FULL  = 5'h10;
  localparam int         SEQ_W      = 16;

  // Reset values
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
  localparam logic [15:0] SEQ_RST    = 16'h0000;

  // Transfer modes
  typedef enum logic [1:0] {
    MODE_MM_MM = 2'h0,
    MODE_MM_ST = 2'h1,
    MODE_ST_MM = 2'h2
  } dmai_mode_e;

  // Response port kinds
  typedef enum logic [1:0] {
    RP_MM  = 2'h0,
    RP_ST  = 2'h1,
    RP_OFF = 2'h2
  } dmai_rport_e;

  // Bus slave phase, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACC  = 2'b10
  } dmai_apb_e;

  // One response entry
  typedef struct packed {
    logic        early;
    logic [7:0]  err;
    logic [31:0] bytes;
  } dmai_resp_s;

  // Build options of this instance
  localparam logic        BLD_BURST   = 1'b1;
  localparam logic        BLD_WRAP    = 1'b0;
  localparam logic        BLD_CHAN    = 1'b0;
  localparam logic [2:0]  BLD_CHAN_W  = 3'h0;
  localparam logic [3:0]  BLD_DFIFO   = 4'h4;
  localparam logic [2:0]  BLD_DWIDTH  = 3'h2;
  localparam logic [2:0]  BLD_DESC    = 3'h2;
  localparam dmai_mode_e  BLD_MODE    = MODE_MM_MM;
  localparam logic        BLD_EXT     = 1'b1;
  localparam logic        BLD_ERR     = 1'b0;
  localparam logic [2:0]  BLD_ERR_W   = 3'h0;
  localparam logic [3:0]  BLD_MBURST  = 4'h3;
  localparam logic [4:0]  BLD_MBYTE   = 5'h0A;
  localparam logic        BLD_STRIDE  = 1'b0;
  localparam logic [14:0] BLD_MSTRIDE = 15'h0000;
  localparam logic        BLD_PKT     = 1'b0;
  localparam logic        BLD_PREF    = 1'b0;
  localparam logic        BLD_DYNB    = 1'b0;
  localparam dmai_rport_e BLD_RPORT   = RP_MM;
  localparam logic [1:0]  BLD_XFER    = 2'h0;

  // Capability word one, packed MSB first
  localparam logic [31:0] CFG1_WORD = {
    BLD_MBYTE,
    BLD_MBURST,
    BLD_ERR_W,
    BLD_ERR, BLD_EXT,
    BLD_MODE,
    BLD_DESC,
    BLD_DWIDTH,
    BLD_DFIFO,
    BLD_CHAN_W,
    BLD_CHAN, BLD_WRAP, BLD_BURST
  };

  // Capability word two, top bits reserved as zero
  localparam logic [31:0] CFG2_WORD = {
    9'h000, BLD_XFER,
    BLD_RPORT,
    BLD_DYNB, BLD_PREF, BLD_PKT,
    BLD_MSTRIDE, BLD_STRIDE
  };

endpackage : dmai_pkg

// >>> dmai_resp_mem.sv
`timescale 1ns/100ps
`default_nettype none
module dmai_resp_mem (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           we,
  input  wire logic [dmai_pkg::RESP_AW-1:0]   waddr,
  input  wire dmai_pkg::dmai_resp_s           wdata,
  input  wire logic [dmai_pkg::RESP_AW-1:0]   raddr,
  output var  dmai_pkg::dmai_resp_s           rdata_q
);
  import dmai_pkg::*;

  // Storage, no reset: contents are only read behind the fill count
  dmai_resp_s mem_q [RESP_DEPTH];

  // Write port
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_q[waddr] <= wdata;
    end
  end

  // Registered read; bypass so a word written into an empty FIFO shows at once
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= '0;
    end
    else if (we && (waddr == raddr))
    begin
      rdata_q <= wdata;
    end
    else
    begin
      rdata_q <= mem_q[raddr];
    end
  end

endmodule : dmai_resp_mem
`default_nettype wire

// >>> dmai_seq_track.sv
`timescale 1ns/100ps
`default_nettype none
module dmai_seq_track (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic [1:0]                     take,
  output logic [1:0][dmai_pkg::SEQ_W-1:0]     seq_q
);
  import dmai_pkg::*;

  // One counter per engine: index 0 write engine, index 1 read engine
  logic [SEQ_W-1:0] cnt_q [2];

  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_eng
      // Each descriptor taken moves the next sequence number on; wraps at 16 bits
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cnt_q[g] <= SEQ_RST;
        end
        else if (take[g])
        begin
          cnt_q[g] <= cnt_q[g] + 16'h0001;
        end
      end
      assign seq_q[g] = cnt_q[g];
    end
  endgenerate

endmodule : dmai_seq_track
`default_nettype wire

// >>> dmai_info_regs.sv
`timescale 1ns/100ps
`default_nettype none
module dmai_info_regs (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 resp_push_valid,
  input  wire dmai_pkg::dmai_resp_s resp_push_data,
  output logic                      resp_push_ready,
  output logic                      resp_st_valid,
  output var  dmai_pkg::dmai_resp_s resp_st_data,
  input  wire logic                 resp_st_ready,
  input  wire logic                 wr_take,
  input  wire logic                 rd_take
);
  import dmai_pkg::*;

  // Address match, used by the flush decode and the checks
  function automatic logic is_at(input logic [7:0] a, input logic [7:0] off);
    is_at = (a == off);
  endfunction : is_at

  // Any decoded register
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= OFF_RCTRL);
  endfunction : is_mapped

  // Bus phase tracking
  dmai_apb_e         state_q;        // Phase register
  dmai_apb_e         state_d;        // Next phase
  logic              setup;          // Setup cycle seen
  logic              done;           // Access completes this edge
  logic              fire_rd;        // Completing read
  logic              fire_wr;        // Completing write

  // Read data path
  logic [31:0]       prdata_q;       // Registered read data
  logic [31:0]       prdata_d;       // Mux result at setup
  logic              pslverr_q;      // Registered error flag
  logic              pslverr_d;      // Unmapped decode
  logic              pop_arm_q;      // Setup saw a head to pop
  logic              pop_arm_d;      // Next arm value

  // Response FIFO state
  logic [RESP_AW-1:0] wr_ptr_q;      // Next slot to fill
  logic [RESP_AW-1:0] wr_ptr_d;
  logic [RESP_AW-1:0] rd_ptr_q;      // Head slot
  logic [RESP_AW-1:0] rd_ptr_d;
  logic [RESP_AW-1:0] waddr;         // Memory write address
  logic [4:0]         count_q;       // Entries held
  logic [4:0]         count_d;
  logic               empty;         // No entry held
  logic               push_st;       // Entry stored this edge
  logic               pop;           // Head leaves this edge
  logic               pop_mm;        // Bus pop
  logic               pop_st;        // Stream pop
  logic               flush;         // Software drop of all entries
  dmai_resp_s         head;          // Head word, from a register

  // Derived register contents
  logic [15:0]        fill_val;      // Visible fill level
  logic               seq_zero;      // Sequence fields forced to zero
  logic [1:0][15:0]   seq;           // Sequence counters

  // Phase decode
  assign setup   = psel && !penable;
  assign done    = psel && penable && (state_q == ST_ACC);
  assign fire_rd = done && !pwrite;
  assign fire_wr = done && pwrite;

  // Zero wait states: every access completes in its first access cycle
  assign pready  = done;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // Next phase; a setup right after an access starts a new transfer
  always_comb
  begin
    state_d = ST_IDLE;
    case (state_q)
      ST_IDLE:
      begin
        state_d = setup ? ST_ACC : ST_IDLE;
      end
      ST_ACC:
      begin
        state_d = setup ? ST_ACC : ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Visible fill level; a disabled port always shows an empty queue
  assign fill_val = (BLD_RPORT == RP_OFF) ? 16'h0000 : {11'h000, count_q};

  // No sequence fields without extended features, none in memory-to-stream
  assign seq_zero = !BLD_EXT || (BLD_MODE == MODE_MM_ST);

  // Read mux, evaluated in the setup cycle so data leaves a flip-flop
  always_comb
  begin
    prdata_d  = PRDATA_RST;
    pslverr_d = !is_mapped(paddr);
    pop_arm_d = 1'b0;
    case (paddr)
      OFF_RESP_BYTES:
      begin
        // Response words only exist behind a memory-mapped response port
        if ((BLD_RPORT == RP_MM) && !empty)
        begin
          prdata_d = head.bytes;
        end
      end
      OFF_RESP_INFO:
      begin
        if ((BLD_RPORT == RP_MM) && !empty)
        begin
          prdata_d         = {24'h000000, head.err};
          prdata_d[ET_BIT] = head.early;
          pop_arm_d        = !pwrite;
        end
      end
      OFF_FILL:
      begin
        prdata_d = {16'h0000, fill_val};
      end
      OFF_WSEQ:
      begin
        prdata_d = seq_zero ? PRDATA_RST : {16'h0000, seq[0]};
      end
      OFF_RSEQ:
      begin
        prdata_d = seq_zero ? PRDATA_RST : {16'h0000, seq[1]};
      end
      OFF_CFG1:
      begin
        prdata_d = CFG1_WORD;
      end
      OFF_CFG2:
      begin
        prdata_d = CFG2_WORD;
      end
      default:
      begin
        // Control word reads zero; unmapped reads zero with an error
        prdata_d = PRDATA_RST;
      end
    endcase
  end

  // Read data and error registers, loaded once per transfer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_q  <= PRDATA_RST;
      pslverr_q <= 1'b0;
      pop_arm_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
      pop_arm_q <= pop_arm_d;
    end
  end

  // Only the control word takes writes; all info registers ignore them
  assign flush = fire_wr && is_at(paddr, OFF_RCTRL) && pstrb[0] && pwdata[FLUSH_BIT];

  // A disabled port swallows responses so the engines never stall on it
  assign resp_push_ready = (BLD_RPORT == RP_OFF) || (count_q != RESP_FULL);
  assign push_st         = resp_push_valid && resp_push_ready && (BLD_RPORT != RP_OFF);
  assign empty           = (count_q == 5'h00);

  // Pop only what the setup cycle showed, so a late push is never lost unseen
  assign pop_mm = fire_rd && pop_arm_q;
  assign pop_st = resp_st_valid && resp_st_ready;
  assign pop    = pop_mm || pop_st;

  // Streaming drain, head word straight from the memory's output register
  assign resp_st_valid = (BLD_RPORT == RP_ST) && !empty;
  assign resp_st_data  = head;

  // Pointer and count next values; a push in a flush cycle survives
  always_comb
  begin
    if (flush)
    begin
      waddr    = '0;
      wr_ptr_d = {{(RESP_AW-1){1'b0}}, push_st};
      rd_ptr_d = '0;
      count_d  = {4'h0, push_st};
    end
    else
    begin
      waddr    = wr_ptr_q;
      wr_ptr_d = wr_ptr_q + {{(RESP_AW-1){1'b0}}, push_st};
      rd_ptr_d = rd_ptr_q + {{(RESP_AW-1){1'b0}}, pop};
      count_d  = count_q + {4'h0, push_st} - {4'h0, pop};
    end
  end

  // FIFO pointers and fill count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= 5'h00;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
    end
  end

  // Response storage; read address runs one step ahead so the head is current
  dmai_resp_mem u_mem (
    .clk     (clk),
    .rst_n   (rst_n),
    .we      (push_st),
    .waddr   (waddr),
    .wdata   (resp_push_data),
    .raddr   (rd_ptr_d),
    .rdata_q (head)
  );

  // Next-descriptor sequence numbers of both engines
  dmai_seq_track u_seq (
    .clk   (clk),
    .rst_n (rst_n),
    .take  ({rd_take, wr_take}),
    .seq_q (seq)
  );

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  fill_read_a: assert property (
    (setup && !pwrite && is_at(paddr, OFF_FILL)) |=>
      (prdata == {16'h0000, (BLD_RPORT == RP_OFF) ? 16'h0000 : {11'h000, $past(count_q)}}))
    else $error("fill level read wrong");

  fill_count_a: assert property (
    !flush |=> (count_q == 5'($past(count_q) + {4'h0, $past(push_st)} - {4'h0, $past(pop)})))
    else $error("fill count out of step");

  stream_drain_a: assert property (
    resp_st_valid |-> ((BLD_RPORT == RP_ST) && (count_q != 5'h00)))
    else $error("stream valid without entry");

  seq_read_a: assert property (
    (setup && !pwrite && is_at(paddr, OFF_WSEQ)) |=>
      (prdata == (seq_zero ? 32'h0 : {16'h0000, $past(seq[0])})))
    else $error("write sequence read wrong");

  seq_rd_read_a: assert property (
    (setup && !pwrite && is_at(paddr, OFF_RSEQ)) |=>
      (prdata == (seq_zero ? 32'h0 : {16'h0000, $past(seq[1])})))
    else $error("read sequence read wrong");

  // Each take pulse moves the next write-engine number on by one
  seq_step_a: assert property (
    wr_take |=> (seq[0] == 16'($past(seq[0]) + 16'h0001)))
    else $error("write sequence did not advance");

  early_bit_a: assert property (
    (setup && !pwrite && is_at(paddr, OFF_RESP_INFO) && !empty && (BLD_RPORT == RP_MM)) |=>
      ((prdata[ET_BIT] == $past(head.early)) && (prdata[31:9] == 23'h0)))
    else $error("early termination bit wrong");

  cfg_one_a: assert property (
    (setup && !pwrite && is_at(paddr, OFF_CFG1)) ##1 done |-> (prdata == CFG1_WORD))
    else $error("config word one wrong");

  cfg_two_a: assert property (
    (setup && !pwrite && is_at(paddr, OFF_CFG2)) |=> (prdata == CFG2_WORD) && (prdata[31:23] == 9'h0))
    else $error("config word two wrong");

  bus_pop_a: assert property (
    (fire_rd && pop_arm_q) |=> (rd_ptr_q == 4'($past(rd_ptr_q) + 4'h1)))
    else $error("bus read did not pop");

  // A write anywhere but the control word must leave the queue alone
  ro_write_a: assert property (
    (fire_wr && !is_at(paddr, OFF_RCTRL) && !push_st && !pop_st) |=>
      (count_q == $past(count_q)))
    else $error("write to read-only register acted");

  // An empty queue read must neither pop nor wrap the head pointer
  empty_nopop_a: assert property (
    ((BLD_RPORT == RP_MM) && setup && !pwrite && is_at(paddr, OFF_RESP_INFO) && empty)
      ##1 done |=> (rd_ptr_q == $past(rd_ptr_q, 2)))
    else $error("empty response read popped");

  // Zero wait states: the first access cycle always completes
  zero_wait_a: assert property (
    (psel && penable) |-> pready)
    else $error("access cycle not answered");

  unmapped_a: assert property (
    (setup && !is_mapped(paddr)) |=> pslverr && (prdata == 32'h0))
    else $error("unmapped access not refused");

  full_stall_a: assert property (
    ((count_q == RESP_FULL) && (BLD_RPORT != RP_OFF)) |-> !resp_push_ready)
    else $error("push accepted when full");

  bus_pop_c:    cover property (fire_rd && pop_arm_q);
  stream_pop_c: cover property (pop_st ##1 pop_st);
  fifo_full_c:  cover property (count_q == RESP_FULL);
  flush_push_c: cover property (flush && push_st);
  seq_take_c:   cover property (wr_take && rd_take);

endmodule : dmai_info_regs
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dmai_pkg::*;

  // Capability words built field by field
  localparam logic [31:0] CFG1_EXP = (32'(BLD_MBYTE) << 27) | (32'(BLD_MBURST) << 23)
    | (32'(BLD_ERR_W) << 20) | (32'(BLD_ERR) << 19) | (32'(BLD_EXT) << 18)
    | (32'(BLD_MODE) << 16) | (32'(BLD_DESC) << 13) | (32'(BLD_DWIDTH) << 10)
    | (32'(BLD_DFIFO) << 6) | (32'(BLD_CHAN_W) << 3) | (32'(BLD_CHAN) << 2)
    | (32'(BLD_WRAP) << 1) | 32'(BLD_BURST);
  localparam logic [31:0] CFG2_EXP = (32'(BLD_XFER) << 21) | (32'(BLD_RPORT) << 19)
    | (32'(BLD_DYNB) << 18) | (32'(BLD_PREF) << 17) | (32'(BLD_PKT) << 16)
    | (32'(BLD_MSTRIDE) << 1) | 32'(BLD_STRIDE);

  logic        clk             = 1'b0;   // 125 MHz
  logic        rst_n           = 1'b0;   // Async, active low
  logic        psel            = 1'b0;
  logic        penable         = 1'b0;
  logic        pwrite          = 1'b0;
  logic [7:0]  paddr           = 8'h00;
  logic [31:0] pwdata          = 32'h0000_0000;
  logic [3:0]  pstrb           = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        resp_push_valid = 1'b0;
  dmai_resp_s  resp_push_data  = '0;
  logic        resp_push_ready;
  logic        resp_st_valid;
  dmai_resp_s  resp_st_data;
  logic        resp_st_ready   = 1'b0;
  logic        wr_take         = 1'b0;
  logic        rd_take         = 1'b0;
  logic [31:0] lfsr_q          = 32'h0001_52B6;  // Seed 86710
  logic [31:0] st_lfsr_q       = 32'h0001_52B6;
  logic [32:0] exp_q[$];                         // Notes: {pslverr, prdata}
  dmai_resp_s  sent_q[$];                        // Entries still held
  logic [32:0] note;
  dmai_resp_s  r;
  int          n_fail     = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  int          nw         = 0;
  int          nr         = 0;

  dmai_info_regs i_dmai_info_regs (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .resp_push_valid(resp_push_valid), .resp_push_data(resp_push_data),
    .resp_push_ready(resp_push_ready), .resp_st_valid(resp_st_valid),
    .resp_st_data(resp_st_data), .resp_st_ready(resp_st_ready),
    .wr_take(wr_take), .rd_take(rd_take)
  );

  // Clock
  always #4 clk = ~clk;

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = s[0] ? ((s >> 1) ^ 32'hD000_0001) : (s >> 1);
  endfunction : next_rand

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // One APB transfer; request held until pready is sampled high
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the answer; only the hang guard ends a stuck wait
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  // Read with a note of what should come back
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    exp_q.push_back({err, e});
    apb_xfer(1'b0, a, 32'h0000_0000, 4'h0);
  endtask : rd

  // Random response entry, pushed through the handshake
  task automatic push_resp();
    int n;
    lfsr_q = next_rand(lfsr_q);
    r.early = lfsr_q[31];
    r.err   = lfsr_q[15:8];
    lfsr_q  = next_rand(lfsr_q);
    r.bytes = lfsr_q;
    @(posedge clk);
    resp_push_valid <= 1'b1;
    resp_push_data  <= r;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (resp_push_ready !== 1'b1 && n < 50);
    resp_push_valid <= 1'b0;
    sent_q.push_back(r);
  endtask : push_resp

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  // Far side of the unused stream port, random ready
  always @(posedge clk)
  begin
    st_lfsr_q     <= next_rand(st_lfsr_q);
    resp_st_ready <= st_lfsr_q[0];
  end

  // Read monitor: oldest note against each completed read
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      if (exp_q.size() == 0)
        n_fail++;
      else
      begin
        note = exp_q.pop_front();
        check(prdata, note[31:0]);
        check({31'h0, pslverr}, {31'h0, note[32]});
      end
    end
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Capability words, then writes that must not stick
    rd(OFF_CFG1, CFG1_EXP, 1'b0);
    rd(OFF_CFG2, CFG2_EXP, 1'b0);
    for (int i = 0; i < 5; i++)
      apb_xfer(1'b1, OFF_FILL + 8'(4 * i), 32'hFFFF_FFFF, 4'hF);
    rd(OFF_CFG1, CFG1_EXP, 1'b0);
    rd(OFF_CFG2, CFG2_EXP, 1'b0);
    rd(OFF_FILL, 32'h0, 1'b0);
    rd(OFF_WSEQ, 32'h0, 1'b0);
    // Unmapped and misaligned places
    rd(8'h20, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    rd(8'hFC, 32'h0, 1'b1);
    // Random take pulses, a quiet cycle after each
    repeat (40)
    begin
      @(posedge clk);
      lfsr_q = next_rand(lfsr_q);
      wr_take <= lfsr_q[0];
      rd_take <= lfsr_q[1];
      nw += lfsr_q[0];
      nr += lfsr_q[1];
      @(posedge clk);
      wr_take <= 1'b0;
      rd_take <= 1'b0;
    end
    rd(OFF_WSEQ, 32'(nw), 1'b0);
    rd(OFF_RSEQ, 32'(nr), 1'b0);
    // Fill the response store to the brim
    repeat (RESP_DEPTH)
    begin
      push_resp();
      rd(OFF_FILL, 32'(sent_q.size()), 1'b0);
    end
    @(posedge clk);
    resp_push_valid <= 1'b1;
    repeat (3) @(posedge clk);
    check({31'h0, resp_push_ready}, 32'h0);
    check({31'h0, resp_st_valid}, 32'h0);
    resp_push_valid <= 1'b0;
    rd(OFF_FILL, 32'(RESP_DEPTH), 1'b0);
    // Drain over the bus; the info word pops
    while (sent_q.size() > 0)
    begin
      r = sent_q.pop_front();
      rd(OFF_RESP_BYTES, r.bytes, 1'b0);
      rd(OFF_RESP_INFO, {23'h0, r.early, r.err}, 1'b0);
      rd(OFF_FILL, 32'(sent_q.size()), 1'b0);
    end
    // Empty read must not pop or underflow
    rd(OFF_RESP_INFO, 32'h0, 1'b0);
    rd(OFF_FILL, 32'h0, 1'b0);
    // Flush control word
    repeat (3) push_resp();
    apb_xfer(1'b1, OFF_RCTRL, 32'h0000_0001, 4'h1);
    sent_q.delete();
    rd(OFF_FILL, 32'h0, 1'b0);
    // Reset in mid-run clears fill and sequence counts
    push_resp();
    do_reset();
    sent_q.delete();
    rd(OFF_FILL, 32'h0, 1'b0);
    rd(OFF_WSEQ, 32'h0, 1'b0);
    rd(OFF_RSEQ, 32'h0, 1'b0);
    repeat (2) @(posedge clk);
    report_and_stop();
  end

endmodule : tb_top
`default_nettype wire
